/* include/pdft_pkg.sv */
`default_nettype none
package pdft_pkg;
	// Transform geometry: N-point prime transform, N-1 correlator taps
	localparam int PDFT_N = 7;
	localparam int PDFT_TAPS = PDFT_N - 1;
	localparam int PDFT_ROOT = 3;
	localparam int PDFT_DW = 16;
	localparam int PDFT_AW = 32;
	localparam int PDFT_IDXW = 3;
	// Each complex tap spans two filter stages, one per interleaved word
	localparam int PDFT_STAGES = 2 * PDFT_TAPS;
	localparam int PDFT_SIW = 4;
	// Coefficient memory address: bank bit above stage index
	localparam int PDFT_CAW = PDFT_SIW + 1;
	// Zero words written to flush the delay-and-add chain
	localparam logic [3:0] PDFT_FLUSH_WORDS = 4'hc;
	// Output words of partial results after start
	localparam logic [4:0] PDFT_PARTIAL_WORDS = 5'h0b;
	// Reset values
	localparam logic PDFT_SWAP_RST = 1'b0;
	localparam logic [PDFT_IDXW-1:0] PDFT_IDX_RST = 3'h0;
	typedef logic signed [PDFT_DW-1:0] pdft_word_t;
	typedef logic signed [PDFT_AW-1:0] pdft_acc_t;
	// Sequencer states
	typedef enum logic [1:0] {
		PDFT_IDLE,
		PDFT_FLUSH,
		PDFT_STREAM
	} pdft_state_t;
endpackage
`default_nettype wire

/* include/pdft_if.sv */
`default_nettype none
interface pdft_if;
	import pdft_pkg::*;
	logic in_valid;
	pdft_word_t in_word;
	pdft_acc_t cascade_in;
	logic coef_we;
	logic [PDFT_CAW-1:0] coef_addr;
	pdft_word_t coef_wdata;
	pdft_word_t coef_rdata;
	logic out_valid;
	pdft_acc_t out_word;
	logic out_imag;
	modport engine (
		input in_valid, in_word, cascade_in, coef_we, coef_addr, coef_wdata,
		output coef_rdata, out_valid, out_word, out_imag
	);
	modport feeder (
		output in_valid, in_word, cascade_in, coef_we, coef_addr, coef_wdata,
		input coef_rdata, out_valid, out_word, out_imag
	);
endinterface
`default_nettype wire

/* core/pdft_engine.sv */
`default_nettype none
module pdft_engine
	import pdft_pkg::*;
(
	input wire logic sys_clk_i, // 40 MHz clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic swap_mode_i, // Continuous bank-swap selected
	output logic bank_b_active_o, // Bank B computes this cycle
	pdft_if.engine link // Filter and memory port
);
	import pdft_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Two banks of coefficients; index 0 is the rightmost tap
	pdft_word_t coef_mem [2][PDFT_STAGES];
	pdft_acc_t chain_q [PDFT_STAGES];
	pdft_acc_t chain_d [PDFT_STAGES]; // Next value of each stage
	logic bank_b_q;
	logic out_valid_q;
	logic out_imag_q;
	pdft_acc_t out_word_q;
	pdft_word_t rdata_q;

	// Host port always reaches the idle bank
	wire logic host_bank = link.coef_addr[PDFT_CAW-1];
	wire logic [PDFT_SIW-1:0] host_idx = link.coef_addr[PDFT_SIW-1:0];
	// Between words no bank computes, so both banks are open to loads
	wire logic host_ok = (!link.in_valid || host_bank != bank_b_q) &&
		(host_idx < PDFT_SIW'(PDFT_STAGES));
	// Next bank: toggles per input word in swap mode
	wire logic bank_b_d = swap_mode_i ? (link.in_valid ? ~bank_b_q : bank_b_q) : 1'b0;

	////////////////////////////////////////////////////////////////////
	// Bank select; real word always meets bank A
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bank_b_q <= PDFT_SWAP_RST;
		end else begin
			bank_b_q <= bank_b_d;
		end
	end

	// Host writes and reads; writes to the busy bank are dropped
	always_ff @(posedge sys_clk_i) begin
		if (link.coef_we && host_ok) begin
			coef_mem[host_bank][host_idx] <= link.coef_wdata;
		end
		rdata_q <= host_ok ? coef_mem[host_bank][host_idx] : '0;
	end

	////////////////////////////////////////////////////////////////////
	// Transposed delay-and-add chain; tap 0 is the rightmost stage
	// Leftmost stage takes the cascade input so devices chain directly
	generate
		for (genvar t = 0; t < PDFT_STAGES; t++) begin : g_tap
			wire pdft_acc_t prod = PDFT_AW'(link.in_word * coef_mem[bank_b_q][t]);
			wire pdft_acc_t upstream;
			if (t == PDFT_STAGES - 1) begin : g_left
				assign upstream = link.cascade_in;
			end else begin : g_mid
				assign upstream = chain_q[t+1];
			end
			assign chain_d[t] = upstream + prod;
			// Chain holds when no word arrives; reset clears the sums
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					chain_q[t] <= '0;
				end else if (link.in_valid) begin
					chain_q[t] <= chain_d[t];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Result register; the sum closed by an imaginary word is a real part
	// and the one closed by a real word an imaginary part
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			out_valid_q <= 1'b0;
			out_imag_q <= 1'b0;
			out_word_q <= '0;
		end else begin
			out_valid_q <= link.in_valid;
			if (link.in_valid) begin
				out_word_q <= chain_d[0];
				out_imag_q <= ~bank_b_q;
			end
		end
	end

	assign link.coef_rdata = rdata_q;
	assign link.out_valid = out_valid_q;
	assign link.out_word = out_word_q;
	assign link.out_imag = out_imag_q;
	assign bank_b_active_o = bank_b_q;
endmodule
`default_nettype wire

/* core/pdft_feeder.sv */
`default_nettype none
module pdft_feeder
	import pdft_pkg::*;
(
	input wire logic sys_clk_i, // 40 MHz clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic start_i, // Begin continuous transforms
	input wire logic stop_i, // End after current pass
	input wire logic sample_we_i, // Load an input sample
	input wire logic [PDFT_IDXW-1:0] sample_idx_i, // Sample index n
	input wire pdft_word_t sample_re_i, // Real part
	input wire pdft_word_t sample_im_i, // Imaginary part
	input wire pdft_word_t twiddle_re_i, // Twiddle real part for root^k
	input wire pdft_word_t twiddle_imag_part_i, // Twiddle imaginary part
	output logic [PDFT_IDXW-1:0] twiddle_addr_o, // Twiddle store address
	output logic busy_o, // Streaming or flushing
	output logic bin_valid_o, // Bin result valid
	output logic [PDFT_IDXW-1:0] bin_idx_o, // Bin number k
	output logic bin_imag_o, // Result is imaginary part
	output pdft_acc_t bin_word_o, // Corrected result word
	output pdft_acc_t dc_re_o, // Zero-frequency real sum
	output pdft_acc_t dc_im_o, // Zero-frequency imaginary sum
	pdft_if.feeder link // Filter and memory port
);
	import pdft_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Power table of the primitive root, used for loads and labels
	function automatic logic [PDFT_IDXW-1:0] root_pow(input logic [PDFT_IDXW-1:0] e);
		logic [PDFT_IDXW-1:0] lut [PDFT_TAPS];
		lut = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
		return lut[e];
	endfunction

	pdft_state_t state_q, state_d;
	logic [3:0] flush_q;
	logic [PDFT_IDXW-1:0] tw_q; // Twiddle counter
	logic half_q; // 0 real word, 1 imaginary word
	logic [4:0] skip_q; // Partial words still to drop
	logic [PDFT_IDXW-1:0] obin_q;
	logic ohalf_q;
	pdft_word_t first_re_q, first_im_q; // first_sample_real / imag
	pdft_acc_t dc_re_q, dc_im_q;
	// Sample zero opens a block, so the sums restart there
	wire pdft_acc_t dc_re_base = (sample_idx_i == '0) ? '0 : dc_re_q;
	wire pdft_acc_t dc_im_base = (sample_idx_i == '0) ? '0 : dc_im_q;
	logic bin_valid_q, bin_imag_q;
	logic [PDFT_IDXW-1:0] bin_idx_q;
	pdft_acc_t bin_word_q;
	logic [PDFT_CAW-1:0] caddr_q;
	pdft_word_t cdata_q;
	logic cwe_q;

	////////////////////////////////////////////////////////////////////
	// Sequencer decode
	wire logic last_tw = (tw_q == PDFT_IDXW'(PDFT_TAPS - 1));
	wire logic streaming = (state_q == PDFT_STREAM);
	wire logic flushing = (state_q == PDFT_FLUSH);
	// Slot whose sample is root^(N-2-i) for sample index n
	wire logic [PDFT_IDXW-1:0] samp_slot = slot_of(sample_idx_i);
	wire logic samp_perm = (sample_idx_i != '0) && (sample_idx_i < PDFT_IDXW'(PDFT_N));
	// Next output label
	wire logic [PDFT_IDXW-1:0] out_bin = root_pow(obin_q);
	wire logic drop = (skip_q != '0);

	function automatic logic [PDFT_IDXW-1:0] slot_of(input logic [PDFT_IDXW-1:0] n);
		logic [PDFT_IDXW-1:0] s;
		s = '0;
		for (int i = 0; i < PDFT_TAPS; i++) begin
			if (root_pow(PDFT_IDXW'(PDFT_TAPS - 1 - i)) == n) begin
				s = PDFT_IDXW'(i);
			end
		end
		return s;
	endfunction

	// State transitions: flush once, then stream back to back
	always_comb begin
		state_d = state_q;
		case (state_q)
			PDFT_IDLE: begin
				if (start_i) begin
					state_d = PDFT_FLUSH;
				end
			end
			PDFT_FLUSH: begin
				if (flush_q == PDFT_FLUSH_WORDS - 4'h1) begin
					state_d = PDFT_STREAM;
				end
			end
			PDFT_STREAM: begin
				if (stop_i && last_tw && half_q) begin
					state_d = PDFT_IDLE;
				end
			end
			default: state_d = PDFT_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Word feed: zero during flush, then twiddles real then imag
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q <= PDFT_IDLE;
			flush_q <= '0;
			tw_q <= PDFT_IDX_RST;
			half_q <= 1'b0;
		end else begin
			state_q <= state_d;
			flush_q <= flushing ? flush_q + 4'h1 : '0;
			if (streaming) begin
				half_q <= ~half_q;
				if (half_q) begin
					tw_q <= last_tw ? '0 : tw_q + 3'h1; // recirculate
				end
			end else begin
				half_q <= 1'b0;
				tw_q <= PDFT_IDX_RST;
			end
		end
	end

	// Inputs to the engine are registered so they stay gapless
	logic in_valid_q;
	pdft_word_t in_word_q;
	logic in_stream_q; // Word on the link is a twiddle, not a flush zero
	logic out_stream_q; // Engine result belongs to a twiddle word
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			in_valid_q <= 1'b0;
			in_word_q <= '0;
			in_stream_q <= 1'b0;
			out_stream_q <= 1'b0;
		end else begin
			in_valid_q <= flushing || streaming;
			in_stream_q <= streaming;
			out_stream_q <= link.in_valid && in_stream_q;
			in_word_q <= streaming ? (half_q ? twiddle_imag_part_i : twiddle_re_i) : '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sample loads: slot m takes four writes. Odd stage 2m+1 holds re in
	// both banks, bank B even stage 2m holds -im and bank A even stage of
	// slot m+1 holds im, so each result pairs parts of the same twiddle.
	// Loads take four cycles; space samples at least four apart
	logic [2:0] wph_q; // Write phase, 0 when no load is pending
	logic [PDFT_IDXW-1:0] lslot_q; // Slot of the latched sample
	pdft_word_t lre_q, lim_q; // Latched sample parts
	wire logic [PDFT_IDXW-1:0] next_slot = (lslot_q == PDFT_IDXW'(PDFT_TAPS - 1)) ? '0 :
		lslot_q + 3'h1;
	// Stage index counts from the rightmost register as zero
	wire logic [PDFT_SIW-1:0] odd_stage = {lslot_q, 1'b1};
	wire logic [PDFT_SIW-1:0] even_stage = {lslot_q, 1'b0};
	wire logic [PDFT_SIW-1:0] wrap_stage = {next_slot, 1'b0};
	wire logic [PDFT_CAW-1:0] wr_addr = (wph_q == 3'h1) ? {1'b0, odd_stage} :
		(wph_q == 3'h2) ? {1'b1, odd_stage} :
		(wph_q == 3'h3) ? {1'b0, wrap_stage} : {1'b1, even_stage};
	wire pdft_word_t wr_data = (wph_q == 3'h1 || wph_q == 3'h2) ? lre_q :
		(wph_q == 3'h3) ? lim_q : -lim_q;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cwe_q <= 1'b0;
			caddr_q <= '0;
			cdata_q <= '0;
			wph_q <= 3'h0;
			lslot_q <= '0;
			lre_q <= '0;
			lim_q <= '0;
		end else begin
			cwe_q <= (wph_q != 3'h0);
			caddr_q <= wr_addr;
			cdata_q <= wr_data;
			if (sample_we_i && samp_perm) begin
				wph_q <= 3'h1;
				lslot_q <= samp_slot;
				lre_q <= sample_re_i;
				lim_q <= sample_im_i;
			end else if (wph_q != 3'h0) begin
				wph_q <= (wph_q == 3'h4) ? 3'h0 : wph_q + 3'h1;
			end
		end
	end

	// DC sum and first sample capture
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			dc_re_q <= '0;
			dc_im_q <= '0;
			first_re_q <= '0;
			first_im_q <= '0;
		end else if (sample_we_i) begin
			dc_re_q <= dc_re_base + PDFT_AW'(sample_re_i);
			dc_im_q <= dc_im_base + PDFT_AW'(sample_im_i);
			if (sample_idx_i == '0) begin
				first_re_q <= sample_re_i;
				first_im_q <= sample_im_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output side: drop partial words, label bins, add first sample
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || state_q == PDFT_IDLE) begin
			skip_q <= PDFT_PARTIAL_WORDS;
			obin_q <= '0;
			ohalf_q <= 1'b0;
			bin_valid_q <= 1'b0;
			bin_imag_q <= 1'b0;
			bin_idx_q <= '0;
			bin_word_q <= '0;
		end else begin
			bin_valid_q <= 1'b0;
			if (link.out_valid && out_stream_q) begin
				if (drop) begin
					skip_q <= skip_q - 5'h1;
				end else begin
					bin_valid_q <= 1'b1;
					bin_imag_q <= ohalf_q;
					bin_idx_q <= out_bin;
					bin_word_q <= link.out_word + PDFT_AW'(ohalf_q ? first_im_q : first_re_q);
					ohalf_q <= ~ohalf_q;
					if (ohalf_q) begin
						obin_q <= (obin_q == PDFT_IDXW'(PDFT_TAPS - 1)) ? '0 : obin_q + 3'h1;
					end
				end
			end
		end
	end

	assign link.in_valid = in_valid_q;
	assign link.in_word = in_word_q;
	assign link.cascade_in = '0; // Single device: nothing chained ahead
	assign link.coef_we = cwe_q;
	assign link.coef_addr = caddr_q;
	assign link.coef_wdata = cdata_q;
	assign twiddle_addr_o = tw_q;
	assign busy_o = in_valid_q;
	assign bin_valid_o = bin_valid_q;
	assign bin_idx_o = bin_idx_q;
	assign bin_imag_o = bin_imag_q;
	assign bin_word_o = bin_word_q;
	assign dc_re_o = dc_re_q;
	assign dc_im_o = dc_im_q;
endmodule
`default_nettype wire

/* dv/pdft_checker.sv */
`default_nettype none
module pdft_checker
	import pdft_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic reset_i, // Sync reset
	input wire logic swap_mode_i, // Swap select
	input wire logic bank_b_active_o, // Bank B in use
	input wire logic in_valid, // Word strobe
	input wire pdft_word_t in_word, // Fed word
	input wire logic coef_we, // Coef write
	input wire logic [PDFT_CAW-1:0] coef_addr, // Coef address
	input wire logic out_valid, // Result strobe
	input wire logic out_imag // Result is imaginary
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	logic [3:0] fed_q; // Words fed, saturating at the flush length
	////////////////////////////////////////
	// Counts opening words; saturating keeps later streams out of the flush check
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			fed_q <= 4'h0;
		end else if (in_valid && fed_q != PDFT_FLUSH_WORDS) begin
			fed_q <= fed_q + 4'h1;
		end
	end
	////////////////////////////////////////
	valid_latency_a: assert property (in_valid |=> out_valid)
		else $error("result missing");
	no_spurious_a: assert property (!in_valid |=> !out_valid)
		else $error("result without word");
	bank_toggle_a: assert property (swap_mode_i && in_valid |=> bank_b_active_o != $past(bank_b_active_o))
		else $error("bank did not swap");
	bank_hold_a: assert property (swap_mode_i && !in_valid |=> $stable(bank_b_active_o))
		else $error("bank moved idle");
	bank_a_only_a: assert property (!swap_mode_i ##1 !swap_mode_i |-> !bank_b_active_o)
		else $error("bank B without swap");
	first_word_a: assert property ($rose(in_valid) |-> !bank_b_active_o)
		else $error("stream opens on bank B");
	imag_alternate_a: assert property (out_valid ##1 out_valid && swap_mode_i |-> out_imag != $past(out_imag))
		else $error("parts not alternating");
	flush_zero_a: assert property (in_valid && fed_q < PDFT_FLUSH_WORDS |-> in_word == '0)
		else $error("flush word not zero");
	gapless_feed_a: assert property ($rose(in_valid) |-> in_valid [*8])
		else $error("gap in feed");
	tap_range_a: assert property (coef_we |-> coef_addr[PDFT_SIW-1:0] < 4'hc)
		else $error("write past last tap");
endmodule
`default_nettype wire

/* dv/tb_prime_number_dft_engine.sv */
`default_nettype none
module tb_prime_number_dft_engine import pdft_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i, reset_i, swap_mode_i, start_i, stop_i, sample_we_i; // Drivers
	logic [PDFT_IDXW-1:0] sample_idx_i, twiddle_addr_o, bin_idx_o; // Indices
	pdft_word_t sample_re_i, sample_im_i, tw_re[8], tw_im[8], xr[7], xi[7]; // Data
	logic bank_b_active_o, busy_o, bin_valid_o, bin_imag_o; // Flags
	pdft_acc_t bin_word_o, dc_re_o, dc_im_o, er[7], ei[7]; // Results and expectations
	int fail_count, n_tests, seed, words; // Bookkeeping
	pdft_if link_if ();
	pdft_engine pdft_engine_inst (.sys_clk_i, .reset_i, .swap_mode_i, .bank_b_active_o,
		.link(link_if.engine));
	pdft_feeder pdft_feeder_inst (.sys_clk_i, .reset_i, .start_i, .stop_i, .sample_we_i,
		.sample_idx_i, .sample_re_i, .sample_im_i, .twiddle_re_i(tw_re[twiddle_addr_o]),
		.twiddle_imag_part_i(tw_im[twiddle_addr_o]), .twiddle_addr_o, .busy_o, .bin_valid_o,
		.bin_idx_o, .bin_imag_o, .bin_word_o, .dc_re_o, .dc_im_o, .link(link_if.feeder));
	pdft_checker pdft_checker_inst (.sys_clk_i, .reset_i, .swap_mode_i, .bank_b_active_o,
		.in_valid(link_if.in_valid), .in_word(link_if.in_word), .coef_we(link_if.coef_we),
		.coef_addr(link_if.coef_addr), .out_valid(link_if.out_valid),
		.out_imag(link_if.out_imag));
	////////////////////////////////////////
	// Compare and count; an unknown matches only the same unknown
	task automatic check(input string what, input pdft_acc_t seen, input pdft_acc_t exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Power of the primitive root modulo N
	function automatic int rpow(input int p);
		int v;
		v = 1;
		repeat (p) v = v * PDFT_ROOT % PDFT_N;
		return v;
	endfunction
	task automatic complete_run();
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////
	// Free-running 40 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// Hang guard, well beyond four passes
	initial begin
		#500000;
		fail_count++;
		complete_run();
	end
	// Past the flush every word is the stored twiddle, real then imaginary
	always @(negedge sys_clk_i) begin
		if (!reset_i && link_if.in_valid === 1'b1) begin
			if (words >= 12) begin
				check("feed", link_if.in_word, words[0] ? tw_im[(words - 12) / 2 % 6] :
					tw_re[(words - 12) / 2 % 6]);
			end
			words++;
		end else begin
			words = 0; // Each start opens with a fresh flush
		end
	end
	////////////////////////////////////////
	// Load a block, stream until all bins arrive, then stop
	task automatic run_pass(input bit corner);
		int nb, c, k;
		pdft_acc_t sr, si;
		sr = 0;
		si = 0;
		for (int n = 0; n < PDFT_N; n++) begin
			@(negedge sys_clk_i);
			xr[n] = corner ? 16'sh7fff : pdft_word_t'($random(seed) % 4000);
			// Most negative value left out: its negation in a bank would wrap
			xi[n] = corner ? 16'sh8001 : pdft_word_t'($random(seed) % 4000);
			{sample_we_i, sample_idx_i, sample_re_i, sample_im_i} = {1'b1, 3'(n), xr[n], xi[n]};
			sr += xr[n];
			si += xi[n];
			@(negedge sys_clk_i);
			sample_we_i = 1'b0; // Four coefficient writes follow each sample except sample 0
			repeat (3) @(negedge sys_clk_i);
		end
		// Bins as x0 plus the correlation with the stored twiddles
		for (k = 1; k < PDFT_N; k++) begin
			er[k] = xr[0];
			ei[k] = xi[0];
			for (int n = 1; n < PDFT_N; n++)
				for (int p = 0; p < PDFT_TAPS; p++)
					if (rpow(p) == n * k % PDFT_N) begin
						er[k] += xr[n] * tw_re[p] - xi[n] * tw_im[p];
						ei[k] += xr[n] * tw_im[p] + xi[n] * tw_re[p];
					end
		end
		@(negedge sys_clk_i);
		{sample_we_i, start_i, stop_i} = 3'b010;
		nb = 0;
		for (c = 0; c < 3000 && nb < 12; c++) begin
			@(posedge sys_clk_i);
			#1;
			if (bin_valid_o === 1'b1) begin
				k = rpow(nb / 2);
				check("bin", bin_idx_o, k);
				check("imag", bin_imag_o, nb % 2);
				check("word", bin_word_o, nb[0] ? ei[k] : er[k]);
				nb++;
			end
		end
		check("bins", nb, 12);
		@(negedge sys_clk_i);
		{start_i, stop_i} = 2'b01;
		for (c = 0; c < 3000 && busy_o !== 1'b0; c++) @(negedge sys_clk_i);
		stop_i = 1'b0;
		check("dc re", dc_re_o, sr);
		check("dc im", dc_im_o, si);
	endtask
	// Reset with swap off, then the corner block and random blocks
	initial begin
		seed = 32'hedca;
		{reset_i, swap_mode_i, start_i, stop_i, sample_we_i} = 5'b10000;
		{sample_idx_i, sample_re_i, sample_im_i, fail_count, n_tests, words} = '0;
		for (int p = 0; p < 8; p++) begin
			tw_re[p] = pdft_word_t'($random(seed) % 128);
			tw_im[p] = pdft_word_t'($random(seed) % 128);
		end
		repeat (12) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		reset_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		swap_mode_i = 1'b1;
		run_pass(1'b1);
		repeat (3) run_pass(1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
